// ==== hdl/alrx_pkg.sv ====
// Constants shared by the asynchronous receive port and interrupt status block
package alrx_pkg;
    // Host byte addresses of the quadlet registers
    localparam logic [8:0] ALRX_OFS_TXRQ_NEXT = 9'h088;
    localparam logic [8:0] ALRX_OFS_TXRQ_LAST = 9'h08c;
    localparam logic [8:0] ALRX_OFS_TXRP_NEXT = 9'h090;
    localparam logic [8:0] ALRX_OFS_TXRP_LAST = 9'h094;
    localparam logic [8:0] ALRX_OFS_RX_REQ = 9'h098;
    localparam logic [8:0] ALRX_OFS_RX_RSP = 9'h09c;
    localparam logic [8:0] ALRX_OFS_STATUS = 9'h0a0;
    localparam logic [8:0] ALRX_OFS_ENABLE = 9'h0a4;

    localparam int ALRX_EVT_W = 17;
    localparam int ALRX_QUAD_W = 32;

    // Event bit positions in the status and enable registers
    localparam int ALRX_B_TX_REQ_WRITTEN = 0;
    localparam int ALRX_B_TX_RSP_WRITTEN = 1;
    localparam int ALRX_B_TX_REQ_WR_ERR = 2;
    localparam int ALRX_B_TX_RSP_WR_ERR = 3;
    localparam int ALRX_B_TX_REQ_FULL = 4;
    localparam int ALRX_B_TX_RSP_FULL = 5;
    localparam int ALRX_B_SOLICITED = 6;
    localparam int ALRX_B_TIMEOUT = 7;
    localparam int ALRX_B_REQ_AVAIL = 8;
    localparam int ALRX_B_RSP_AVAIL = 9;
    localparam int ALRX_B_REQ_RD_ERR = 10;
    localparam int ALRX_B_RSP_RD_ERR = 11;
    localparam int ALRX_B_REQ_LAST = 12;
    localparam int ALRX_B_RSP_LAST = 13;
    localparam int ALRX_B_SELF_ID = 14;
    localparam int ALRX_B_RX_REQ_FULL = 15;
    localparam int ALRX_B_RX_RSP_FULL = 16;

    localparam logic [16:0] ALRX_STATUS_RST = 17'h00c00;
    localparam logic [16:0] ALRX_ENABLE_RST = 17'h00000;
    localparam logic [16:0] ALRX_W1C_MASK = 17'h18cff;
    localparam logic [31:0] ALRX_QUAD_RST = 32'h00000000;

    // Byte lane 0 carries bits 31..24; lane 3 ends a quadlet access
    localparam logic [1:0] ALRX_LANE_LAST = 2'h3;
    localparam logic [7:0] ALRX_BYTE_ZERO = 8'h00;
    localparam logic [31:0] ALRX_LANE_ONES = 32'h000000ff;
endpackage

// ==== hdl/alrx_top.sv ====
// Async receive transfer registers, async interrupt status/enable, host byte port
`timescale 1ns/1ns
`default_nettype none

// One receive transfer register fed from the head of a receive queue
module alrx_xfer_reg
    import alrx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    input wire logic [ALRX_QUAD_W-1:0] i_data,
    input wire logic i_last,
    input wire logic i_sid,
    input wire logic i_block,
    input wire logic i_consume,
    output logic [ALRX_QUAD_W-1:0] o_quad,
    output logic o_avail,
    output logic o_last,
    output logic o_sid,
    output logic o_pop
);
    logic load;

    // Reload only once the previous quadlet has gone and reads are not blocked
    assign load = !o_avail && i_valid && !i_block;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_quad <= ALRX_QUAD_RST;
        end else if (load) begin
            o_quad <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avail <= 1'b0;
            o_last <= 1'b0;
            o_sid <= 1'b0;
        end else if (load) begin
            o_avail <= 1'b1;
            o_last <= i_last;
            o_sid <= i_sid;
        end else if (i_consume) begin
            o_avail <= 1'b0;
            o_last <= 1'b0;
            o_sid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pop <= 1'b0;
        end else begin
            o_pop <= load;
        end
    end
endmodule

module alrx_top
    import alrx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [8:0] i_hif_addr,
    input wire logic i_hif_cs_n,
    input wire logic i_hif_rd_n,
    input wire logic i_hif_wr_n,
    input wire logic [7:0] i_hif_data,
    output logic [7:0] o_hif_data,
    output logic o_hif_data_oe,
    output logic o_hif_int_n,
    input wire logic i_rxq_req_valid,
    input wire logic [31:0] i_rxq_req_data,
    input wire logic i_rxq_req_last,
    input wire logic i_rxq_req_sid,
    output logic o_rxq_req_pop,
    input wire logic i_rxq_rsp_valid,
    input wire logic [31:0] i_rxq_rsp_data,
    input wire logic i_rxq_rsp_last,
    output logic o_rxq_rsp_pop,
    input wire logic i_bus_reset,
    input wire logic i_rx_req_full,
    input wire logic i_rx_rsp_full,
    input wire logic i_rx_req_rd_err,
    input wire logic i_rx_rsp_rd_err,
    input wire logic i_split_timeout,
    input wire logic i_solicited_rsp,
    input wire logic i_tx_req_full,
    input wire logic i_tx_rsp_full,
    input wire logic i_tx_req_wr_err,
    input wire logic i_tx_rsp_wr_err,
    input wire logic i_tx_req_moved,
    input wire logic i_tx_rsp_moved
);
    logic rd_n_r;
    logic wr_n_r;
    logic rd_act_r;
    logic [8:0] rd_addr_r;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic [4:0] wr_shift;
    logic [31:0] wr_quad;
    logic [31:0] wr_lanes;
    logic [31:0] rd_quad;
    logic [31:0] rd_shifted;
    logic [16:0] sticky_r;
    logic [16:0] sticky_set;
    logic [16:0] sticky_clr;
    logic [16:0] enable_r;
    logic [16:0] status_view;
    logic sid_win_r;
    logic req_consume;
    logic rsp_consume;
    logic [31:0] req_quad;
    logic [31:0] rsp_quad;
    logic req_avail;
    logic rsp_avail;
    logic req_last;
    logic rsp_last;
    logic req_sid;
    logic wr_word_end;

    // Host strobes are sampled; a read acts at its start, side effects at its end
    assign rd_start = !i_hif_cs_n && !i_hif_rd_n && rd_n_r;
    assign rd_end = rd_act_r && (i_hif_rd_n || i_hif_cs_n);
    assign wr_end = !i_hif_cs_n && i_hif_wr_n && !wr_n_r;
    assign wr_shift = {~i_hif_addr[1:0], 3'b000};
    assign wr_quad = {24'h000000, i_hif_data} << wr_shift;
    assign wr_lanes = ALRX_LANE_ONES << wr_shift;
    assign wr_word_end = wr_end && (i_hif_addr[1:0] == ALRX_LANE_LAST);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
        end else begin
            rd_n_r <= i_hif_rd_n;
            wr_n_r <= i_hif_wr_n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_act_r <= 1'b0;
            rd_addr_r <= '0;
        end else if (rd_start) begin
            rd_act_r <= 1'b1;
            rd_addr_r <= i_hif_addr;
        end else if (rd_end) begin
            rd_act_r <= 1'b0;
        end
    end

    assign req_consume = rd_end && (rd_addr_r[8:2] == ALRX_OFS_RX_REQ[8:2])
        && (rd_addr_r[1:0] == ALRX_LANE_LAST) && !sticky_r[ALRX_B_REQ_RD_ERR] && req_avail;
    assign rsp_consume = rd_end && (rd_addr_r[8:2] == ALRX_OFS_RX_RSP[8:2])
        && (rd_addr_r[1:0] == ALRX_LANE_LAST) && !sticky_r[ALRX_B_RSP_RD_ERR] && rsp_avail;

    alrx_xfer_reg u_req (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_valid(i_rxq_req_valid),
        .i_data(i_rxq_req_data),
        .i_last(i_rxq_req_last),
        .i_sid(i_rxq_req_sid && sid_win_r),
        .i_block(sticky_r[ALRX_B_REQ_RD_ERR]),
        .i_consume(req_consume),
        .o_quad(req_quad),
        .o_avail(req_avail),
        .o_last(req_last),
        .o_sid(req_sid),
        .o_pop(o_rxq_req_pop)
    );

    alrx_xfer_reg u_rsp (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_valid(i_rxq_rsp_valid),
        .i_data(i_rxq_rsp_data),
        .i_last(i_rxq_rsp_last),
        .i_sid(1'b0),
        .i_block(sticky_r[ALRX_B_RSP_RD_ERR]),
        .i_consume(rsp_consume),
        .o_quad(rsp_quad),
        .o_avail(rsp_avail),
        .o_last(rsp_last),
        .o_sid(),
        .o_pop(o_rxq_rsp_pop)
    );

    // self-ID window opens at bus reset, closes on first non-self-ID quadlet
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sid_win_r <= 1'b0;
        end else if (i_bus_reset) begin
            sid_win_r <= 1'b1;
        end else if (o_rxq_req_pop && !req_sid) begin
            sid_win_r <= 1'b0;
        end
    end

    always_comb begin
        sticky_set = '0;
        sticky_set[ALRX_B_RX_RSP_FULL] = i_rx_rsp_full;
        sticky_set[ALRX_B_RX_REQ_FULL] = i_rx_req_full;
        sticky_set[ALRX_B_RSP_RD_ERR] = i_rx_rsp_rd_err || i_bus_reset;
        sticky_set[ALRX_B_REQ_RD_ERR] = i_rx_req_rd_err || i_bus_reset;
        sticky_set[ALRX_B_TIMEOUT] = i_split_timeout;
        sticky_set[ALRX_B_SOLICITED] = i_solicited_rsp;
        sticky_set[ALRX_B_TX_RSP_FULL] = i_tx_rsp_full;
        sticky_set[ALRX_B_TX_REQ_FULL] = i_tx_req_full;
        sticky_set[ALRX_B_TX_RSP_WR_ERR] = i_tx_rsp_wr_err;
        sticky_set[ALRX_B_TX_REQ_WR_ERR] = i_tx_req_wr_err;
        sticky_set[ALRX_B_TX_RSP_WRITTEN] = i_tx_rsp_moved;
        sticky_set[ALRX_B_TX_REQ_WRITTEN] = i_tx_req_moved;
    end

    always_comb begin
        sticky_clr = '0;
        // only ones in writable positions clear
        if (wr_end && (i_hif_addr[8:2] == ALRX_OFS_STATUS[8:2])) begin
            sticky_clr = wr_quad[16:0] & ALRX_W1C_MASK;
        end
        // transmit register write drops its written flag
        if (wr_word_end && (i_hif_addr[8:2] == ALRX_OFS_TXRQ_NEXT[8:2]
                || i_hif_addr[8:2] == ALRX_OFS_TXRQ_LAST[8:2])) begin
            sticky_clr[ALRX_B_TX_REQ_WRITTEN] = 1'b1;
        end
        if (wr_word_end && (i_hif_addr[8:2] == ALRX_OFS_TXRP_NEXT[8:2]
                || i_hif_addr[8:2] == ALRX_OFS_TXRP_LAST[8:2])) begin
            sticky_clr[ALRX_B_TX_RSP_WRITTEN] = 1'b1;
        end
    end

    // reset value; an event in the clearing cycle wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sticky_r <= ALRX_STATUS_RST;
        end else begin
            sticky_r <= ((sticky_r & ~sticky_clr) | sticky_set) & ALRX_W1C_MASK
                | (ALRX_STATUS_RST & ~ALRX_W1C_MASK);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            enable_r <= ALRX_ENABLE_RST;
        end else if (wr_end && (i_hif_addr[8:2] == ALRX_OFS_ENABLE[8:2])) begin
            enable_r <= (enable_r & ~wr_lanes[16:0]) | wr_quad[16:0];
        end
    end

    always_comb begin
        status_view = sticky_r;
        status_view[ALRX_B_REQ_AVAIL] = req_avail;
        status_view[ALRX_B_RSP_AVAIL] = rsp_avail;
        status_view[ALRX_B_REQ_LAST] = req_last;
        status_view[ALRX_B_RSP_LAST] = rsp_last;
        status_view[ALRX_B_SELF_ID] = req_sid;
    end

    always_comb begin
        rd_quad = ALRX_QUAD_RST;
        unique case (i_hif_addr[8:2])
            ALRX_OFS_RX_REQ[8:2]: rd_quad = sticky_r[ALRX_B_REQ_RD_ERR] ? ALRX_QUAD_RST
                : req_quad;
            ALRX_OFS_RX_RSP[8:2]: rd_quad = sticky_r[ALRX_B_RSP_RD_ERR] ? ALRX_QUAD_RST
                : rsp_quad;
            ALRX_OFS_STATUS[8:2]: rd_quad = {15'h0000, status_view};
            ALRX_OFS_ENABLE[8:2]: rd_quad = {15'h0000, enable_r};
            default: rd_quad = ALRX_QUAD_RST;
        endcase
    end
    assign rd_shifted = rd_quad >> wr_shift;

    // Data is captured once at read start so a reload cannot tear the byte
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_hif_data <= ALRX_BYTE_ZERO;
            o_hif_data_oe <= 1'b0;
        end else if (rd_start) begin
            o_hif_data <= rd_shifted[7:0];
            o_hif_data_oe <= 1'b1;
        end else if (rd_end) begin
            o_hif_data_oe <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_hif_int_n <= 1'b1;
        end else begin
            o_hif_int_n <= ~|(status_view & enable_r);
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_req_read_clear: assert property (req_consume |=> !req_avail)
        else $error("request available not cleared by read");
    a_rsp_read_clear: assert property (rsp_consume |=> !rsp_avail)
        else $error("response available not cleared by read");
    a_stat_top_zero: assert property (
        rd_start && i_hif_addr == ALRX_OFS_STATUS |=> o_hif_data == ALRX_BYTE_ZERO)
        else $error("status upper byte not zero");
    a_full_stays_set: assert property (
        sticky_r[ALRX_B_RX_RSP_FULL] && !sticky_clr[ALRX_B_RX_RSP_FULL]
        |=> sticky_r[ALRX_B_RX_RSP_FULL])
        else $error("response full flag lost without clear");
    a_sid_with_avail: assert property (req_sid |-> req_avail)
        else $error("self-ID flag without quadlet");
    a_rderr_blocks_read: assert property (
        rd_start && i_hif_addr[8:2] == ALRX_OFS_RX_REQ[8:2]
        && sticky_r[ALRX_B_REQ_RD_ERR] |=> o_hif_data == ALRX_BYTE_ZERO ##1 !req_consume)
        else $error("blocked request queue was readable");
    a_timeout_sets: assert property (i_split_timeout |=> sticky_r[ALRX_B_TIMEOUT])
        else $error("timeout event not recorded");
    a_txreq_write_clears: assert property (
        wr_word_end && i_hif_addr[8:2] == ALRX_OFS_TXRQ_LAST[8:2] && !i_tx_req_moved
        |=> !sticky_r[ALRX_B_TX_REQ_WRITTEN])
        else $error("transmit request written flag not cleared");
    a_irq_follows: assert property (
        |(status_view & enable_r) |=> !o_hif_int_n)
        else $error("interrupt not raised for enabled event");
    a_zero_write_keeps: assert property (
        wr_end && i_hif_addr == ALRX_OFS_STATUS + 9'h002 && i_hif_data == ALRX_BYTE_ZERO
        && sticky_r[ALRX_B_REQ_RD_ERR] |=> sticky_r[ALRX_B_REQ_RD_ERR])
        else $error("zero write cleared a sticky bit");
endmodule

`default_nettype wire

// ==== testbench/alrx_rxq_model.sv ====
// Model of the head of one receive queue that feeds a transfer register
`timescale 1ns/1ns
`default_nettype none
module alrx_rxq_model (
    input wire logic i_clk,
    input wire logic i_pop,
    output logic o_valid,
    output logic [31:0] o_data,
    output logic o_last,
    output logic o_sid
);
    logic [33:0] fifo[$];
    initial begin
        o_valid = 1'b0;
        o_data = 32'h00000000;
        o_last = 1'b0;
        o_sid = 1'b0;
    end
    task automatic push(input logic [33:0] w);
        fifo.push_back(w);
    endtask
    // An empty queue shows changing garbage so stale head data cannot pass
    always @(posedge i_clk) begin
        if (i_pop && fifo.size() > 0) begin
            void'(fifo.pop_front());
        end
        if (fifo.size() > 0) begin
            o_valid <= 1'b1;
            {o_last, o_sid, o_data} <= fifo[0];
        end else begin
            o_valid <= 1'b0;
            o_data <= ~o_data;
            o_last <= ~o_last;
            o_sid <= ~o_sid;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/test_async_rx_port_and_irq_status.sv ====
// Testbench for the async receive port and interrupt status block
`timescale 1ns/1ns
`default_nettype none
module test_async_rx_port_and_irq_status
    import alrx_pkg::*;
();
    logic i_clk, i_srst, cs_n, rd_n, wr_n, bus_reset, oe, int_n;
    logic [8:0] addr;
    logic [7:0] wdata, rdata;
    logic req_pop, rsp_pop, req_v, req_l, req_s, rsp_v, rsp_l;
    logic [31:0] req_d, rsp_d, rd;
    logic [16:0] ev;
    int miscompares = 0;
    int samples_checked = 0;
    int req_pops = 0;
    int rsp_pops = 0;

    // Count queue pops so a lost or doubled pop shows up
    always @(posedge i_clk) begin
        if (req_pop === 1'b1) begin
            req_pops <= req_pops + 1;
        end
        if (rsp_pop === 1'b1) begin
            rsp_pops <= rsp_pops + 1;
        end
    end

    alrx_top alrx_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_hif_addr(addr),
        .i_hif_cs_n(cs_n), .i_hif_rd_n(rd_n), .i_hif_wr_n(wr_n), .i_hif_data(wdata),
        .o_hif_data(rdata), .o_hif_data_oe(oe), .o_hif_int_n(int_n),
        .i_rxq_req_valid(req_v), .i_rxq_req_data(req_d), .i_rxq_req_last(req_l),
        .i_rxq_req_sid(req_s), .o_rxq_req_pop(req_pop), .i_rxq_rsp_valid(rsp_v),
        .i_rxq_rsp_data(rsp_d), .i_rxq_rsp_last(rsp_l), .o_rxq_rsp_pop(rsp_pop),
        .i_bus_reset(bus_reset), .i_rx_req_full(ev[15]), .i_rx_rsp_full(ev[16]),
        .i_rx_req_rd_err(ev[10]), .i_rx_rsp_rd_err(ev[11]), .i_split_timeout(ev[7]),
        .i_solicited_rsp(ev[6]), .i_tx_req_full(ev[4]), .i_tx_rsp_full(ev[5]),
        .i_tx_req_wr_err(ev[2]), .i_tx_rsp_wr_err(ev[3]), .i_tx_req_moved(ev[0]),
        .i_tx_rsp_moved(ev[1]));
    alrx_rxq_model req_m (.i_clk(i_clk), .i_pop(req_pop), .o_valid(req_v),
        .o_data(req_d), .o_last(req_l), .o_sid(req_s));
    alrx_rxq_model rsp_m (.i_clk(i_clk), .i_pop(rsp_pop), .o_valid(rsp_v),
        .o_data(rsp_d), .o_last(rsp_l), .o_sid());

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd8(input logic [8:0] a, output logic [7:0] d);
        @(posedge i_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        repeat (3) @(posedge i_clk);
        d = rdata;
        chk("oe", 32'h1, {31'h0, oe});
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("oe", 32'h0, {31'h0, oe});
    endtask
    // Lane 0 holds the top byte; the lane 3 read ends the quadlet
    task automatic rd32(input logic [8:0] a, output logic [31:0] q);
        logic [7:0] b;
        for (int l = 0; l < 4; l++) begin
            rd8(a + 9'(l), b);
            q = {q[23:0], b};
        end
    endtask
    task automatic wr8(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        wdata <= d;
        repeat (2) @(posedge i_clk);
        wr_n <= 1'b1;
        @(posedge i_clk);
        cs_n <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic wr32(input logic [8:0] a, input logic [31:0] v);
        for (int l = 0; l < 4; l++) begin
            wr8(a + 9'(l), v[31 - 8 * l -: 8]);
        end
    endtask
    task automatic st(input logic [31:0] e);
        logic [31:0] q;
        rd32(ALRX_OFS_STATUS, q);
        chk("status", e, q);
    endtask
    task automatic pulse(input logic [16:0] m);
        @(posedge i_clk);
        ev <= m;
        @(posedge i_clk);
        ev <= 17'h00000;
        repeat (2) @(posedge i_clk);
    endtask

    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 9'h000;
        wdata = 8'h00;
        ev = 17'h00000;
        bus_reset = 1'b0;
        i_srst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        st(32'h00000c00);
        rd32(ALRX_OFS_ENABLE, rd);
        chk("enable", 32'h00000000, rd);
        rd32(ALRX_OFS_RX_REQ, rd);
        chk("rx_req", 32'h00000000, rd);
        rd32(ALRX_OFS_RX_RSP, rd);
        chk("rx_rsp", 32'h00000000, rd);
        chk("int_n", 32'h1, {31'h0, int_n});
        wr32(ALRX_OFS_STATUS, 32'h00000000);
        st(32'h00000c00);
        wr32(ALRX_OFS_STATUS, 32'h00000c00);
        st(32'h00000000);
        wr32(ALRX_OFS_ENABLE, 32'hffffffff);
        rd32(ALRX_OFS_ENABLE, rd);
        chk("enable", 32'h0001ffff, rd);
        for (int b = 0; b < ALRX_EVT_W; b++) begin
            if (ALRX_W1C_MASK[b]) begin
                pulse(17'h00001 << b);
                st(32'h00000001 << b);
                chk("int_n", 32'h0, {31'h0, int_n});
                wr32(ALRX_OFS_STATUS, 32'h00000001 << b);
                st(32'h00000000);
                chk("int_n", 32'h1, {31'h0, int_n});
            end
        end
        wr32(ALRX_OFS_ENABLE, 32'h0001ff7f);
        pulse(17'h00080);
        chk("int_n", 32'h1, {31'h0, int_n});
        wr32(ALRX_OFS_ENABLE, 32'h0001ffff);
        repeat (3) @(posedge i_clk);
        chk("int_n", 32'h0, {31'h0, int_n});
        wr32(ALRX_OFS_STATUS, 32'h00000080);
        pulse(17'h00001);
        wr32(ALRX_OFS_TXRQ_LAST, 32'h12345678);
        st(32'h00000000);
        pulse(17'h00002);
        wr32(ALRX_OFS_TXRP_NEXT, 32'h9abcdef0);
        st(32'h00000000);
        req_m.push({2'b00, 32'ha1b2c3d4});
        req_m.push({2'b10, 32'h0badf00d});
        rsp_m.push({2'b10, 32'h5566aa99});
        repeat (6) @(posedge i_clk);
        st(32'h00002300);
        rd32(ALRX_OFS_RX_REQ, rd);
        chk("rx_req", 32'ha1b2c3d4, rd);
        repeat (4) @(posedge i_clk);
        st(32'h00003300);
        rd32(ALRX_OFS_RX_REQ, rd);
        chk("rx_req", 32'h0badf00d, rd);
        st(32'h00002200);
        chk("req_pops", 32'h2, req_pops);
        rd32(ALRX_OFS_RX_RSP, rd);
        chk("rx_rsp", 32'h5566aa99, rd);
        st(32'h00000000);
        chk("rsp_pops", 32'h1, rsp_pops);
        @(posedge i_clk);
        bus_reset <= 1'b1;
        @(posedge i_clk);
        bus_reset <= 1'b0;
        req_m.push({2'b01, 32'h00ff0011});
        repeat (4) @(posedge i_clk);
        st(32'h00000c00);
        rd32(ALRX_OFS_RX_REQ, rd);
        chk("rx_req", 32'h00000000, rd);
        rd32(ALRX_OFS_RX_RSP, rd);
        chk("rx_rsp", 32'h00000000, rd);
        wr32(ALRX_OFS_STATUS, 32'h00000c00);
        repeat (4) @(posedge i_clk);
        st(32'h00004100);
        wr32(ALRX_OFS_STATUS, 32'h00004100);
        st(32'h00004100);
        rd32(ALRX_OFS_RX_REQ, rd);
        chk("rx_req", 32'h00ff0011, rd);
        st(32'h00000000);
        chk("req_pops", 32'h3, req_pops);
        report_and_stop();
    end
endmodule
`default_nettype wire
